// File: rtl/adc_powerdown_serial_readout.sv
// Converter digital side: power-down control, conversion engine and serial readout
`timescale 1ns/1ps
module adc_powerdown_serial_readout
    import adc_readout_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
) (
    input wire logic core_clk,                 // 100 MHz core clock
    input wire logic sys_rst,                  // Async reset, active high
    input wire logic link_clk,                 // Serial clock from host
    input wire logic host_cs_n,                // Chip select, active low
    input wire logic read_not_convert,         // High: read frame, low: convert frame
    input wire logic analog_sleep_in,          // Analog power-down request
    input wire logic reference_off_in,         // Internal reference power-down request
    input wire logic [WORD_W-1:0] sample_code, // Code from the analog core
    output logic serial_result_out,            // Serial data out
    output logic msb_parallel_out,             // Parallel MSB carrying serial data
    output logic msb_parallel_oe_n,            // Low while MSB pin is driven
    output logic busy_n,                       // Low during a conversion
    output logic result_invalid,               // Published word came from a sleeping core
    output logic analog_enable,                // Analog circuitry powered
    output logic reference_enable              // Internal reference powered
);
    // ---------------- Link domain ----------------
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic frame_read;
    logic conv_tgl;
    logic read_done_tgl;
    logic [WORD_W:0] link_word;
    logic [WORD_W:0] pub_word;

    // Frame tracking; each frame ends on its own bit count since the clock stops
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt <= BIT_CNT_RESET;
            frame_read <= 1'b0;
            conv_tgl <= 1'b0;
            read_done_tgl <= 1'b0;
        end else if (!host_cs_n) begin
            if (bit_cnt == BIT_CNT_RESET) begin
                frame_read <= read_not_convert;
                if (!read_not_convert) begin
                    conv_tgl <= ~conv_tgl;
                end
            end
            if (bit_cnt == BIT_CNT_W'(CONV_FRAME_BITS - 1) && !frame_read
                && bit_cnt != BIT_CNT_RESET) begin
                bit_cnt <= BIT_CNT_RESET;
            end else if (bit_cnt == BIT_CNT_W'(READ_FRAME_BITS - 1) && frame_read) begin
                bit_cnt <= BIT_CNT_RESET;
                read_done_tgl <= ~read_done_tgl;
            end else begin
                bit_cnt <= bit_cnt + BIT_CNT_W'(1);
            end
        end
    end

    // Word snapshot at convert frame start; core keeps pub_word quiet across the frame gap
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_word <= '0;
        end else if (!host_cs_n && bit_cnt == BIT_CNT_RESET && !read_not_convert) begin
            link_word <= pub_word;
        end
    end

    // Data changes on falling edges so the host can sample on rising ones
    always_ff @(negedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_result_out <= 1'b0;
            msb_parallel_out <= 1'b0;
        end else if (bit_cnt == BIT_CNT_RESET && !frame_read) begin
            serial_result_out <= link_word[WORD_W-1];
            msb_parallel_out <= link_word[WORD_W-1];
        end else if (bit_cnt != BIT_CNT_RESET && frame_read) begin
            serial_result_out <= link_word[WORD_W-1-32'(bit_cnt)];
            msb_parallel_out <= link_word[WORD_W-1-32'(bit_cnt)];
        end
    end

    // ---------------- Core domain ----------------
    logic conv_sync1, conv_sync2, conv_seen;
    logic done_sync1, done_sync2, done_seen;
    logic cs_sync1, cs_sync2;
    logic rc_sync1, rc_sync2;
    logic sleep_sync1, sleep_sync2;
    logic refoff_sync1, refoff_sync2;
    logic conv_pulse;
    logic read_pulse;

    // Two-stage synchronisers for every input from the pin side
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {conv_sync1, conv_sync2, conv_seen} <= 3'h0;
            {done_sync1, done_sync2, done_seen} <= 3'h0;
            {cs_sync1, cs_sync2} <= 2'h3;
            {rc_sync1, rc_sync2} <= 2'h3;
            {sleep_sync1, sleep_sync2} <= 2'h0;
            {refoff_sync1, refoff_sync2} <= 2'h0;
        end else begin
            conv_sync1 <= conv_tgl;
            conv_sync2 <= conv_sync1;
            conv_seen <= conv_sync2;
            done_sync1 <= read_done_tgl;
            done_sync2 <= done_sync1;
            done_seen <= done_sync2;
            cs_sync1 <= host_cs_n;
            cs_sync2 <= cs_sync1;
            rc_sync1 <= read_not_convert;
            rc_sync2 <= rc_sync1;
            sleep_sync1 <= analog_sleep_in;
            sleep_sync2 <= sleep_sync1;
            refoff_sync1 <= reference_off_in;
            refoff_sync2 <= refoff_sync1;
        end
    end

    assign conv_pulse = conv_sync2 ^ conv_seen;
    assign read_pulse = done_sync2 ^ done_seen;

    // Power control outputs follow the inputs; nothing digital is gated by them
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            analog_enable <= 1'b1;
            reference_enable <= 1'b1;
        end else begin
            analog_enable <= ~sleep_sync2;
            reference_enable <= ~refoff_sync2;
        end
    end

    // MSB pin floats while both selects are high, freeing the shared line
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            msb_parallel_oe_n <= 1'b1;
        end else begin
            msb_parallel_oe_n <= cs_sync2 & rc_sync2;
        end
    end

    conv_state_t state;
    logic [$clog2(CONV_LEN+1)-1:0] conv_cnt;
    logic [WORD_W:0] conv_word;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [WORD_W:0] buf_out_data;

    // Conversion engine; starts while busy are ignored, a full buffer stalls it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            conv_cnt <= '0;
            conv_word <= '0;
            busy_n <= 1'b1;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (conv_pulse) begin
                        state <= ST_CONVERT;
                        conv_cnt <= ($clog2(CONV_LEN+1))'(CONV_LEN - 1);
                        conv_word[WORD_W] <= sleep_sync2;
                        busy_n <= 1'b0;
                    end
                end
                ST_CONVERT: begin
                    if (conv_cnt == '0) begin
                        conv_word[WORD_W-1:0] <= sample_code;
                        state <= ST_STORE;
                    end else begin
                        conv_cnt <= conv_cnt - 1'b1;
                    end
                end
                ST_STORE: begin
                    if (buf_in_ready) begin
                        state <= ST_IDLE;
                        busy_n <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Finished results wait here until a read frame ends; a stalled reader loses none
    result_buffer #(
        .W(WORD_W + 1),
        .DEPTH(BUF_DEPTH)
    ) u_result_buffer (
        .clk(core_clk),
        .rst(sys_rst),
        .in_valid(state == ST_STORE),
        .in_ready(buf_in_ready),
        .in_data(conv_word),
        .out_valid(buf_out_valid),
        .out_ready(read_pulse),
        .out_data(buf_out_data)
    );

    // Published word: buffer head, or the last one when nothing is pending
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pub_word <= {1'b0, RESULT_RESET};
            result_invalid <= 1'b0;
        end else if (buf_out_valid) begin
            pub_word <= buf_out_data;
            result_invalid <= buf_out_data[WORD_W];
        end
    end
endmodule

// File: rtl/adc_readout_pkg.sv
// Shared constants and types for the converter digital side and serial readout
package adc_readout_pkg;
    localparam int WORD_W = 16;             // Conversion result width
    localparam int CONV_FRAME_BITS = 8;     // Length of a conversion-start frame
    localparam int READ_FRAME_BITS = 16;    // Length of a readout frame
    localparam int BIT_CNT_W = 5;           // Frame bit counter width
    localparam int CLK_PERIOD_NS = 10;      // core_clk period
    localparam int CONV_TIME_NS = 20000;    // Conversion time, plain default
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUF_DEPTH = 2;           // Result buffer entries
    localparam logic [WORD_W-1:0] RESULT_RESET = 16'h0000;
    localparam logic [BIT_CNT_W-1:0] BIT_CNT_RESET = 5'h00;

    // Conversion engine states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_CONVERT = 3'b010,
        ST_STORE   = 3'b100
    } conv_state_t;
endpackage

// File: rtl/result_buffer.sv
// Small valid/ready buffer holding finished conversion results
`timescale 1ns/1ps
module result_buffer
    import adc_readout_pkg::*;
#(
    parameter int W = WORD_W + 1,
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic clk,                 // Core clock
    input wire logic rst,                 // Async reset, active high
    input wire logic in_valid,            // Producer offers a word
    output logic in_ready,                // Space available
    input wire logic [W-1:0] in_data,     // Word offered
    output logic out_valid,               // Head entry present
    input wire logic out_ready,           // Consumer takes head
    output logic [W-1:0] out_data         // Head entry
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign in_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer wrap without relying on power-of-two depth
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + CW'(1);
            end else if (pop && !push) begin
                count <= count - CW'(1);
            end
        end
    end
endmodule

// File: dv/adc_readout_sva.sv
// Power-down and shared-line checker for the converter ports
`timescale 1ns/1ps
module adc_readout_sva
    import adc_readout_pkg::*;
#(
    parameter int CONV_LEN = 20
) (
    input wire logic core_clk, // Core clock
    input wire logic sys_rst, // Async reset
    input wire logic host_cs_n, // Select
    input wire logic read_not_convert, // Frame type
    input wire logic analog_sleep_in, // Analog sleep
    input wire logic reference_off_in, // Reference off
    input wire logic msb_parallel_out, // Shared MSB
    input wire logic msb_parallel_oe_n, // MSB drive
    input wire logic serial_result_out, // Serial data
    input wire logic busy_n, // Busy
    input wire logic analog_enable, // Analog power
    input wire logic reference_enable // Reference power
);
    // Inputs pass two sync flops, so four steady samples must show at the outputs
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    sleep_off_a: assert property (analog_sleep_in [*4] |-> !analog_enable)
        else $error("analog on in sleep");
    wake_on_a: assert property (!analog_sleep_in [*4] |-> analog_enable)
        else $error("analog off");
    ref_only_a: assert property ((reference_off_in && !analog_sleep_in) [*4]
        |-> !reference_enable && analog_enable) else $error("reference off wrong");
    ref_on_a: assert property (!reference_off_in [*4] |-> reference_enable)
        else $error("reference off");
    both_down_a: assert property ((analog_sleep_in && reference_off_in) [*4]
        |-> !analog_enable && !reference_enable) else $error("full sleep wrong");
    float_a: assert property ((host_cs_n && read_not_convert) [*4]
        |-> msb_parallel_oe_n) else $error("MSB driven idle");
    drive_a: assert property (!host_cs_n [*4] |-> !msb_parallel_oe_n)
        else $error("MSB not driven");
    mirror_a: assert property (!msb_parallel_oe_n
        |-> msb_parallel_out == serial_result_out) else $error("MSB differs");
    sleep_conv_a: assert property ($fell(host_cs_n) && !read_not_convert
        && analog_sleep_in |-> ##[1:14] !busy_n) else $error("no conversion");
    // Main scenarios reached
    cover property ($rose(busy_n));
    cover property (analog_sleep_in && reference_off_in && !msb_parallel_oe_n);
    cover property (!busy_n && !host_cs_n && read_not_convert);
endmodule
bind adc_powerdown_serial_readout adc_readout_sva #(.CONV_LEN(CONV_LEN)) chk (
    .core_clk, .sys_rst, .host_cs_n, .read_not_convert, .analog_sleep_in, .reference_off_in,
    .msb_parallel_out, .msb_parallel_oe_n, .serial_result_out, .busy_n, .analog_enable,
    .reference_enable);

// File: dv/serial_host_model.sv
// Host serial port model framing conversion starts and readouts
`timescale 1ns/1ps
module serial_host_model
    import adc_readout_pkg::*;
(
    input wire logic miso, // Shared MSB line
    input wire logic busy_n, // Converter busy
    output logic link_clk, // Serial clock
    output logic host_cs_n, // Select, active low
    output logic read_not_convert, // Frame type
    output logic [WORD_W-1:0] rx_word, // Captured word
    output logic rx_done, // High at last read edge
    output logic eoc_seen // Busy rose since start
);
    localparam int HALF_NS = 24;
    // Idle with selects high so nothing looks like a start
    initial begin
        link_clk = 1'b0;
        host_cs_n = 1'b1;
        read_not_convert = 1'b1;
        rx_word = 16'h0000;
        rx_done = 1'b0;
        eoc_seen = 1'b0;
    end
    // Port trusted only after busy rises
    always @(posedge busy_n) eoc_seen = 1'b1;
    // Bit 6 of the command byte picks readout over start
    task automatic frame(input logic [7:0] cmd);
        int n;
        n = cmd[6] ? READ_FRAME_BITS : CONV_FRAME_BITS;
        #7;
        if (!cmd[6]) eoc_seen = 1'b0;
        host_cs_n = 1'b0;
        read_not_convert = cmd[6];
        #(2 * HALF_NS);
        for (int i = 0; i < n; i++) begin
            link_clk = 1'b1;
            rx_word = {rx_word[WORD_W-2:0], miso};
            rx_done = cmd[6] && i == n - 1;
            #HALF_NS;
            link_clk = 1'b0;
            rx_done = 1'b0;
            #HALF_NS;
        end
        host_cs_n = 1'b1;
        read_not_convert = 1'b1;
        #19000;
    endtask
endmodule

// File: dv/tb_adc_powerdown_serial_readout.sv
// Self-checking bench for the converter digital side and serial readout
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_adc_powerdown_serial_readout
    import adc_readout_pkg::*;
;
    localparam int CONV_LEN = 20; // Short conversion keeps the run brief
    logic core_clk, sys_rst, analog_sleep_in, reference_off_in;
    logic link_clk, host_cs_n, read_not_convert, rx_done, eoc_seen;
    logic serial_result_out, msb_parallel_out, msb_parallel_oe_n, busy_n;
    logic result_invalid, analog_enable, reference_enable;
    logic [WORD_W-1:0] sample_code, rx_word;
    logic [WORD_W:0] exp_q[$];
    logic [WORD_W:0] prev, want;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 84452;
    int cycles = 0;
    // Released MSB line reads as the pull-up level
    wire miso = msb_parallel_oe_n ? 1'b1 : msb_parallel_out;
    adc_powerdown_serial_readout #(.CONV_LEN(CONV_LEN)) uut (
        .core_clk, .sys_rst, .link_clk, .host_cs_n, .read_not_convert, .analog_sleep_in,
        .reference_off_in, .sample_code, .serial_result_out, .msb_parallel_out,
        .msb_parallel_oe_n, .busy_n, .result_invalid, .analog_enable, .reference_enable);
    serial_host_model host (
        .miso, .busy_n, .link_clk, .host_cs_n, .read_not_convert, .rx_word, .rx_done,
        .eoc_seen);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Verdict and end of run
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Hang guard, well above the roughly 35300 cycles needed
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            test_done();
        end
    end
    // Data is the snapshot word; the flag belongs to the newest published word
    always @(posedge rx_done) begin
        want = exp_q.pop_front();
        `CHK({result_invalid, rx_word}, want)
    end
    // One start and one readout; the read returns the previous conversion
    task automatic pair(input logic as, input logic ro);
        @(negedge core_clk);
        sample_code = 16'($random(seed));
        analog_sleep_in = as;
        reference_off_in = ro;
        host.frame(8'h20);
        `CHK(eoc_seen, 1'b1)
        `CHK({analog_enable, reference_enable}, {~as, ~ro})
        exp_q.push_back({as, prev[WORD_W-1:0]}); // Flag of the word just published
        prev = {as, sample_code};
        host.frame(8'h61);
    endtask
    initial begin
        sys_rst = 1'b1;
        analog_sleep_in = 1'b0;
        reference_off_in = 1'b0;
        sample_code = 16'h0000;
        prev = {1'b0, RESULT_RESET};
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'b0;
        // Awake, full sleep, reference only, analog only, each read after
        for (int i = 0; i < 7; i++) pair(i == 2 || i == 5, i == 2 || i == 4);
        // Two starts fill the buffer; a third stalls until a read frees room
        @(negedge core_clk);
        sample_code = 16'($random(seed));
        repeat (3) host.frame(8'h20);
        `CHK(busy_n, 1'b0)
        exp_q.push_back({analog_sleep_in, sample_code}); // Oldest unread result
        host.frame(8'h61);
        `CHK(eoc_seen, 1'b1)
        test_done();
    end
endmodule
